// ===== common/enc_pkg.sv
package enc_pkg;

	// pclk rate in kHz, used to turn printed rates into cycle counts
	localparam int CLK_KHZ = 10000;
	localparam int SLOTS_PER_BIT = 8;

	// register indices; byte address is four times the index
	localparam logic [7:0] IDX_DATA_MOD = 8'h4b;
	localparam logic [7:0] IDX_SYM_RATES = 8'h4c;
	localparam logic [7:0] IDX_P0_HIGH = 8'h4d;
	localparam logic [7:0] IDX_P0_LOW = 8'h4e;
	localparam logic [7:0] IDX_P1_HIGH = 8'h4f;
	localparam logic [7:0] IDX_P1_LOW = 8'h50;
	localparam logic [7:0] IDX_P2 = 8'h51;
	localparam int NUM_CFG = 7;
	localparam logic [7:0] IDX_CTRL = 8'h60;
	localparam logic [7:0] IDX_LEN = 8'h61;
	localparam logic [7:0] IDX_STATUS = 8'h62;
	localparam logic [7:0] REG_RESET = 8'h00;

	// tx_data_modulation fields
	localparam int FRAME_STEP_BIT = 7;
	localparam int MILLER_BIT = 6;
	localparam int PULSE_LSB = 4;
	localparam int INVERT_BIT = 3;
	localparam int ENV_LSB = 0;
	// tx_symbol_rates fields
	localparam int PAIR_B_SC_BIT = 7;
	localparam int PAIR_B_RATE_LSB = 4;
	localparam int PAIR_A_SC_BIT = 3;
	localparam int PAIR_A_RATE_LSB = 0;
	// control and length fields
	localparam int CTRL_START_BIT = 0;
	localparam int CTRL_HIGH_FIRST_BIT = 7;
	localparam int LEN_FIRST_LSB = 0;
	localparam int LEN_THIRD_LSB = 4;

	localparam int SC_LOW_KHZ = 424;
	localparam int SC_HIGH_KHZ = 848;
	localparam logic [3:0] SC_LOW_HALF = 4'(CLK_KHZ / (2 * SC_LOW_KHZ));
	localparam logic [3:0] SC_HIGH_HALF = 4'(CLK_KHZ / (2 * SC_HIGH_KHZ));

	// bit rates in kHz by code; codes 0 and 1 are reserved
	localparam int RATE_KHZ [8] = '{26, 26, 26, 53, 106, 212, 424, 848};

	typedef enum logic [2:0] {
		ENV_DIRECT = 3'b000,
		ENV_MANCH = 3'b001,
		ENV_MANCH_SC = 3'b010,
		ENV_BPSK = 3'b011,
		ENV_RZ_LATE = 3'b100,
		ENV_RZ_EARLY = 3'b101
	} env_kind_type;

	typedef enum logic [1:0] {
		PULSE_NONE = 2'b00,
		PULSE_START = 2'b01,
		PULSE_HALF = 2'b10,
		PULSE_QUARTER3 = 2'b11
	} pulse_pos_type;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_LOAD = 3'b001,
		ST_SOF = 3'b010,
		ST_DATA = 3'b011,
		ST_EOF = 3'b100
	} enc_state_type;

	localparam logic [2:0] SLOT_START = 3'h0;
	localparam logic [2:0] SLOT_HALF = 3'h4;
	localparam logic [2:0] SLOT_Q3 = 3'h6;
	localparam logic [2:0] SLOT_LAST = 3'h7;

	// cycles per eighth of a bit, rounded down, never below one
	function automatic logic [7:0] slot_cycles(input logic [2:0] code);
		int c;
		c = CLK_KHZ / (RATE_KHZ[code] * SLOTS_PER_BIT);
		return (c < 1) ? 8'h01 : 8'(c);
	endfunction

endpackage

// ===== design/symbol_timer.sv
`timescale 1ns/10ps
`default_nettype none
module symbol_timer (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic restart,
	input wire logic [2:0] rate_code,
	output logic [2:0] slot,
	output logic bit_end
);

	logic [7:0] cnt;
	logic [7:0] limit;
	logic slot_end;

	assign limit = enc_pkg::slot_cycles(rate_code); // RULE10 RULE12
	assign slot_end = (cnt >= limit - 8'h01);
	assign bit_end = slot_end && (slot == enc_pkg::SLOT_LAST) && !restart;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt <= 8'h00;
			slot <= 3'h0;
		end else if (restart) begin
			cnt <= 8'h00;
			slot <= 3'h0;
		end else if (slot_end) begin
			cnt <= 8'h00;
			slot <= slot + 3'h1;
		end else begin
			cnt <= cnt + 8'h01;
		end
	end

	property p_slot_length;
		@(posedge pclk) disable iff (!presetn)
		($changed(slot) && !$past(restart) && $past(presetn)) |-> ($past(cnt) == $past(limit) - 8'h01);
	endproperty
	a_slot_length: assert property (p_slot_length) else $error("slot advanced early"); // RULE10

endmodule
`default_nettype wire

// ===== design/envelope_shaper.sv
`timescale 1ns/10ps
`default_nettype none
module envelope_shaper (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic active,
	input wire logic pseudo_bit,
	input wire logic prev_bit,
	input wire logic [2:0] slot,
	input wire logic [2:0] env_kind,
	input wire logic [1:0] pulse_pos,
	input wire logic miller,
	input wire logic invert,
	input wire logic sc_sel,
	output logic mod_out
);

	logic [3:0] sc_cnt;
	logic sc_phase;
	logic [3:0] sc_half;
	logic first_half;
	logic env_bit;
	logic pulse_win;
	logic miller_pulse;
	logic next_mod;

	// RULE9 RULE11
	assign sc_half = sc_sel ? enc_pkg::SC_HIGH_HALF : enc_pkg::SC_LOW_HALF;
	assign first_half = (slot < enc_pkg::SLOT_HALF);

	always_comb begin
		case (enc_pkg::env_kind_type'(env_kind)) // RULE8
			enc_pkg::ENV_DIRECT: env_bit = pseudo_bit;
			enc_pkg::ENV_MANCH: env_bit = first_half ? pseudo_bit : !pseudo_bit;
			enc_pkg::ENV_MANCH_SC: env_bit = (first_half ? pseudo_bit : !pseudo_bit) & sc_phase;
			enc_pkg::ENV_BPSK: env_bit = pseudo_bit ^ sc_phase;
			enc_pkg::ENV_RZ_LATE: env_bit = pseudo_bit & !first_half;
			enc_pkg::ENV_RZ_EARLY: env_bit = pseudo_bit & first_half;
			default: env_bit = 1'b0;
		endcase
	end

	always_comb begin
		case (enc_pkg::pulse_pos_type'(pulse_pos)) // RULE5
			enc_pkg::PULSE_START: pulse_win = (slot == enc_pkg::SLOT_START);
			enc_pkg::PULSE_HALF: pulse_win = (slot == enc_pkg::SLOT_HALF);
			enc_pkg::PULSE_QUARTER3: pulse_win = (slot == enc_pkg::SLOT_Q3);
			default: pulse_win = 1'b1;
		endcase
	end

	// a zero after a one carries no pulse, which keeps pauses apart
	assign miller_pulse = pseudo_bit ? (slot == enc_pkg::SLOT_HALF)
		: (!prev_bit && slot == enc_pkg::SLOT_START); // RULE4
	assign next_mod = active && ((miller ? miller_pulse : (env_bit & pulse_win)) ^ invert); // RULE7

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sc_cnt <= 4'h0;
			sc_phase <= 1'b0;
			mod_out <= 1'b0;
		end else begin
			mod_out <= next_mod;
			if (!active || sc_cnt >= sc_half - 4'h1) begin
				sc_cnt <= 4'h0;
				sc_phase <= active ? !sc_phase : 1'b0;
			end else begin
				sc_cnt <= sc_cnt + 4'h1;
			end
		end
	end

	property p_miller_gap;
		@(posedge pclk) disable iff (!presetn)
		(active && miller && !pseudo_bit && prev_bit) |=> (mod_out == $past(invert));
	endproperty
	a_miller_gap: assert property (p_miller_gap) else $error("pulse after a one-zero"); // RULE4

	property p_direct_env;
		@(posedge pclk) disable iff (!presetn)
		(active && !miller && env_kind == 3'h0 && pulse_pos == 2'h0)
			|=> (mod_out == ($past(pseudo_bit) ^ $past(invert)));
	endproperty
	a_direct_env: assert property (p_direct_env) else $error("direct envelope wrong"); // RULE8

endmodule
`default_nettype wire

// ===== design/tx_symbol_encoder.sv
`timescale 1ns/10ps
`default_nettype none
// Contract
// (RULE1) per-byte framing wraps each byte in frame
// (RULE2) per-byte mode self-triggers the next byte
// (RULE3) stream mode frames all queued bytes once
// (RULE4) miller enable applies modified Miller pulses
// (RULE5) pulse position field picks pulse slot
// (RULE6) software pairs Miller with start pulse
// (RULE7) invert bit inverts data envelope
// (RULE8) envelope field selects data envelope shape
// (RULE9) pair B subcarrier 424 or 848 kHz
// (RULE10) pair B bit rate code mapping
// (RULE11) pair A subcarrier 424 or 848 kHz
// (RULE12) pair A bit rate, same mapping
// (RULE13) first pattern is high and low byte
// (RULE14) second pattern is high and low byte
// (RULE15) third pattern is one full byte
// (RULE16) first pattern length code: 0 means one bit
// (RULE17) third pattern length code: 0 means one bit
// (RULE18) order bit picks high or low first
// (RULE19) all registers clear to zero at reset
// (RULE20) reads return last write, no side effects; the ctrl start bit is not stored and reads back as zero
module tx_symbol_encoder (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic tx_valid,
	input wire logic [7:0] tx_byte,
	input wire logic tx_last,
	output logic tx_ready,
	output logic tx_mod,
	output logic tx_active
);

	////////////////////////////////////////////////////////////////////////
	// register file

	logic [7:0] cfg [0:enc_pkg::NUM_CFG-1];
	logic [7:0] ctrl;
	logic [7:0] lens;
	logic [7:0] reg_index;
	logic aligned;
	logic wr;
	logic in_cfg;
	logic [2:0] cfg_sel;
	logic [7:0] status;
	logic [7:0] read_value;
	logic mapped;
	logic start;

	function automatic logic addr_is(input logic ok, input logic [7:0] idx, input logic [7:0] want);
		return ok && (idx == want);
	endfunction

	assign reg_index = paddr[9:2];
	assign aligned = (paddr[1:0] == 2'h0) && (paddr[31:10] == 22'h0);
	assign wr = psel && penable && pwrite;
	assign in_cfg = aligned && (reg_index >= enc_pkg::IDX_DATA_MOD)
		&& (reg_index < enc_pkg::IDX_DATA_MOD + 8'(enc_pkg::NUM_CFG));
	assign cfg_sel = 3'(reg_index - enc_pkg::IDX_DATA_MOD);
	assign mapped = in_cfg || addr_is(aligned, reg_index, enc_pkg::IDX_CTRL)
		|| addr_is(aligned, reg_index, enc_pkg::IDX_LEN)
		|| addr_is(aligned, reg_index, enc_pkg::IDX_STATUS);
	assign start = wr && addr_is(aligned, reg_index, enc_pkg::IDX_CTRL)
		&& pwdata[enc_pkg::CTRL_START_BIT];
	assign pready = 1'b1;
	assign pslverr = psel && penable && !mapped;

	// RULE20
	assign read_value = in_cfg ? cfg[cfg_sel]
		: addr_is(aligned, reg_index, enc_pkg::IDX_CTRL) ? ctrl
		: addr_is(aligned, reg_index, enc_pkg::IDX_LEN) ? lens
		: addr_is(aligned, reg_index, enc_pkg::IDX_STATUS) ? status : enc_pkg::REG_RESET;

	for (genvar i = 0; i < enc_pkg::NUM_CFG; i++) begin : g_cfg
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				cfg[i] <= enc_pkg::REG_RESET; // RULE19
			end else if (wr && in_cfg && cfg_sel == 3'(i)) begin
				cfg[i] <= pwdata[7:0]; // RULE13 RULE14 RULE15
			end
		end
	end

	// start is a strobe and is not stored, so it always reads back as zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl <= enc_pkg::REG_RESET;
			lens <= enc_pkg::REG_RESET;
			prdata <= 32'h0;
		end else begin
			if (wr && addr_is(aligned, reg_index, enc_pkg::IDX_CTRL)) begin
				ctrl <= pwdata[7:0] & ~(8'h01 << enc_pkg::CTRL_START_BIT);
			end
			if (wr && addr_is(aligned, reg_index, enc_pkg::IDX_LEN)) begin
				lens <= pwdata[7:0];
			end
			if (psel && !penable) begin
				prdata <= {24'h0, read_value};
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// configuration fields

	logic [7:0] data_mod;
	logic [7:0] rates;
	logic [15:0] first_pattern;
	logic [15:0] second_pattern;
	logic [7:0] third_pattern;
	logic frame_step;
	logic high_first;
	logic [3:0] first_len;
	logic [2:0] third_len;

	assign data_mod = cfg[3'(enc_pkg::IDX_DATA_MOD - enc_pkg::IDX_DATA_MOD)];
	assign rates = cfg[3'(enc_pkg::IDX_SYM_RATES - enc_pkg::IDX_DATA_MOD)];
	assign first_pattern = {cfg[3'(enc_pkg::IDX_P0_HIGH - enc_pkg::IDX_DATA_MOD)],
		cfg[3'(enc_pkg::IDX_P0_LOW - enc_pkg::IDX_DATA_MOD)]}; // RULE13
	assign second_pattern = {cfg[3'(enc_pkg::IDX_P1_HIGH - enc_pkg::IDX_DATA_MOD)],
		cfg[3'(enc_pkg::IDX_P1_LOW - enc_pkg::IDX_DATA_MOD)]}; // RULE14
	assign third_pattern = cfg[3'(enc_pkg::IDX_P2 - enc_pkg::IDX_DATA_MOD)]; // RULE15
	assign frame_step = data_mod[enc_pkg::FRAME_STEP_BIT];
	assign high_first = ctrl[enc_pkg::CTRL_HIGH_FIRST_BIT];
	assign first_len = lens[enc_pkg::LEN_FIRST_LSB +: 4]; // RULE16
	assign third_len = lens[enc_pkg::LEN_THIRD_LSB +: 3]; // RULE17

	////////////////////////////////////////////////////////////////////////
	// frame sequencer

	enc_pkg::enc_state_type state, next_state;
	logic [3:0] bit_cnt, next_bit_cnt;
	logic [7:0] shift_byte;
	logic frame_open, next_frame_open;
	logic last_taken;
	logic prev_bit;
	logic take;
	logic bit_end;
	logic last_bit;
	logic sym_done;
	logic [2:0] slot;
	logic in_data;
	logic pseudo_bit;
	logic [2:0] rate_code;
	logic sc_sel;
	logic restart;

	assign take = (state == enc_pkg::ST_LOAD) && tx_valid;
	assign tx_ready = (state == enc_pkg::ST_LOAD);
	assign tx_active = (state != enc_pkg::ST_IDLE);
	assign last_bit = (bit_cnt == 4'h0);
	assign sym_done = bit_end && last_bit;
	assign in_data = (state == enc_pkg::ST_DATA);
	assign restart = (state == enc_pkg::ST_IDLE) || (state == enc_pkg::ST_LOAD);
	assign status = {4'h0, frame_open, state};
	// RULE11 RULE12 RULE9 RULE10
	assign rate_code = (state == enc_pkg::ST_EOF) ? rates[enc_pkg::PAIR_B_RATE_LSB +: 3]
		: rates[enc_pkg::PAIR_A_RATE_LSB +: 3];
	assign sc_sel = (state == enc_pkg::ST_EOF) ? rates[enc_pkg::PAIR_B_SC_BIT]
		: rates[enc_pkg::PAIR_A_SC_BIT];

	// patterns go out from their highest valid bit down
	always_comb begin
		case (state)
			enc_pkg::ST_SOF: pseudo_bit = first_pattern[bit_cnt];
			enc_pkg::ST_EOF: pseudo_bit = third_pattern[bit_cnt[2:0]];
			enc_pkg::ST_DATA: pseudo_bit = high_first ? shift_byte[bit_cnt[2:0]]
				: shift_byte[3'h7 - bit_cnt[2:0]]; // RULE18
			default: pseudo_bit = 1'b0;
		endcase
	end

	always_comb begin
		next_state = state;
		next_bit_cnt = bit_cnt;
		next_frame_open = frame_open;
		case (state)
			enc_pkg::ST_IDLE: begin
				if (start) begin
					next_state = enc_pkg::ST_LOAD;
					next_frame_open = 1'b0;
				end
			end
			enc_pkg::ST_LOAD: begin
				if (tx_valid) begin
					next_state = frame_open ? enc_pkg::ST_DATA : enc_pkg::ST_SOF;
					next_bit_cnt = frame_open ? 4'h7 : first_len; // RULE16
				end
			end
			enc_pkg::ST_SOF: begin
				if (sym_done) begin
					next_state = enc_pkg::ST_DATA;
					next_bit_cnt = 4'h7;
					next_frame_open = 1'b1;
				end
			end
			enc_pkg::ST_DATA: begin
				if (sym_done && (frame_step || last_taken)) begin
					next_state = enc_pkg::ST_EOF; // RULE1
					next_bit_cnt = {1'b0, third_len}; // RULE17
				end else if (sym_done) begin
					next_state = enc_pkg::ST_LOAD; // RULE3
				end
			end
			enc_pkg::ST_EOF: begin
				if (sym_done) begin
					next_frame_open = 1'b0;
					// per-byte mode retriggers itself until the last byte
					next_state = (frame_step && !last_taken) ? enc_pkg::ST_LOAD
						: enc_pkg::ST_IDLE; // RULE2
				end
			end
			default: next_state = enc_pkg::ST_IDLE;
		endcase
		if (bit_end && !last_bit) begin
			next_bit_cnt = bit_cnt - 4'h1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= enc_pkg::ST_IDLE;
			bit_cnt <= 4'h0;
			frame_open <= 1'b0;
			shift_byte <= 8'h00;
			last_taken <= 1'b0;
			prev_bit <= 1'b0;
		end else begin
			state <= next_state;
			bit_cnt <= next_bit_cnt;
			frame_open <= next_frame_open;
			if (take) begin
				shift_byte <= tx_byte;
				last_taken <= tx_last;
			end
			if (restart) begin
				prev_bit <= 1'b0;
			end else if (bit_end) begin
				prev_bit <= pseudo_bit;
			end
		end
	end

	symbol_timer u_timer (
		.pclk(pclk),
		.presetn(presetn),
		.restart(restart),
		.rate_code(rate_code),
		.slot(slot),
		.bit_end(bit_end)
	);

	// symbols use a plain envelope; only data takes the data modulation
	envelope_shaper u_shaper (
		.pclk(pclk),
		.presetn(presetn),
		.active(!restart),
		.pseudo_bit(pseudo_bit),
		.prev_bit(prev_bit),
		.slot(slot),
		.env_kind(in_data ? data_mod[enc_pkg::ENV_LSB +: 3] : 3'h0),
		.pulse_pos(in_data ? data_mod[enc_pkg::PULSE_LSB +: 2] : 2'h0),
		.miller(in_data && data_mod[enc_pkg::MILLER_BIT]),
		.invert(in_data && data_mod[enc_pkg::INVERT_BIT]),
		.sc_sel(sc_sel),
		.mod_out(tx_mod)
	);

	////////////////////////////////////////////////////////////////////////
	// checks

	property p_step_eof;
		@(posedge pclk) disable iff (!presetn)
		(in_data && sym_done && frame_step) |=> (state == enc_pkg::ST_EOF);
	endproperty
	a_step_eof: assert property (p_step_eof) else $error("byte not closed by eof"); // RULE1

	property p_step_retrigger;
		@(posedge pclk) disable iff (!presetn)
		(state == enc_pkg::ST_EOF && sym_done && frame_step && !last_taken)
			|=> (state == enc_pkg::ST_LOAD) ##1 (!frame_open);
	endproperty
	a_step_retrigger: assert property (p_step_retrigger) else $error("no self retrigger"); // RULE2

	property p_stream_once;
		@(posedge pclk) disable iff (!presetn)
		(in_data && sym_done && !frame_step && !last_taken)
			|=> (state == enc_pkg::ST_LOAD) && frame_open;
	endproperty
	a_stream_once: assert property (p_stream_once) else $error("stream framed twice"); // RULE3

	property p_sof_len;
		@(posedge pclk) disable iff (!presetn)
		(state == enc_pkg::ST_LOAD && tx_valid && !frame_open) |=> (bit_cnt == $past(first_len));
	endproperty
	a_sof_len: assert property (p_sof_len) else $error("first pattern length wrong"); // RULE16

	property p_eof_len;
		@(posedge pclk) disable iff (!presetn)
		(in_data && sym_done && frame_step) |=> (bit_cnt == {1'b0, $past(third_len)});
	endproperty
	a_eof_len: assert property (p_eof_len) else $error("third pattern length wrong"); // RULE17

	property p_order;
		@(posedge pclk) disable iff (!presetn)
		(in_data && bit_cnt == 4'h7) |-> (pseudo_bit == (high_first ? shift_byte[7] : shift_byte[0]));
	endproperty
	a_order: assert property (p_order) else $error("bit order wrong"); // RULE18

	property p_readback;
		@(posedge pclk) disable iff (!presetn)
		(wr && in_cfg) ##2 (psel && !penable && !pwrite && reg_index == $past(reg_index, 2) && aligned)
			##1 1'b1 |-> (prdata[7:0] == $past(pwdata[7:0], 3));
	endproperty
	a_readback: assert property (p_readback) else $error("readback mismatch"); // RULE20

	property p_reset_zero;
		@(posedge pclk)
		$rose(presetn) |-> (ctrl == enc_pkg::REG_RESET) && (data_mod == enc_pkg::REG_RESET);
	endproperty
	a_reset_zero: assert property (p_reset_zero) else $error("register not cleared"); // RULE19

endmodule
`default_nettype wire

// ===== sim/byte_source.sv
`timescale 1ns/10ps
`default_nettype none
module byte_source (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic tx_ready,
	input wire logic tx_mod,
	input wire logic tx_active,
	output logic tx_valid,
	output logic [7:0] tx_byte,
	output logic tx_last
);
	logic [8:0] pending [$];
	int taken, high_cycles, rise_at, since_start, stall, wait_cnt;
	logic mod_d;
	initial begin
		tx_valid = 1'b0;
		tx_byte = 8'h00;
		tx_last = 1'b0;
		mod_d = 1'b0;
		stall = 0;
		wait_cnt = 0;
	end
	task automatic push(input logic [8:0] e);
		pending.push_back(e);
	endtask
	task automatic clear_counts();
		taken = 0;
		high_cycles = 0;
		since_start = 0;
		rise_at = -1;
	endtask
	////////////////////////////////////////////////////////////////////////
	// a byte is held until the edge that takes it; the rotating stall holds
	// the next byte back for 0 to 2 extra cycles after each take
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_valid <= 1'b0;
			tx_last <= 1'b0;
		end else if (tx_valid && tx_ready) begin
			taken++;
			tx_valid <= 1'b0;
			tx_last <= 1'b0;
			tx_byte <= ~tx_byte;
			wait_cnt = stall;
			stall = (stall + 1) % 3;
		end else if (!tx_valid && pending.size() > 0 && wait_cnt == 0) begin
			tx_valid <= 1'b1;
			{tx_last, tx_byte} <= pending.pop_front();
		end else if (!tx_valid) begin
			// a stale byte must never look valid, so it keeps changing
			tx_byte <= ~tx_byte;
			if (wait_cnt > 0) wait_cnt--;
		end
	end
	////////////////////////////////////////////////////////////////////////
	// the field side only sees the envelope: count its modulated cycles
	always @(posedge pclk) begin
		mod_d <= tx_mod;
		if (tx_active === 1'b1) since_start++;
		if (tx_mod === 1'b1) high_cycles++;
		if (tx_mod === 1'b1 && mod_d !== 1'b1 && rise_at < 0) rise_at = since_start;
	end
endmodule
`default_nettype wire

// ===== sim/test_tx_symbol_encoder.sv
`timescale 1ns/10ps
`default_nettype none
module test_tx_symbol_encoder;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [31:0] paddr, pwdata, prdata, rd;
	logic tx_valid, tx_last, tx_ready, tx_mod, tx_active, er;
	logic [7:0] tx_byte;
	logic [7:0] model_regs [7];
	int errors, checks_done, cycles, seed;
	int env_hi1 [8] = '{8, 4, -1, -1, 4, 4, 0, 0};
	int env_hi0 [8] = '{0, 4, -1, -1, 0, 0, 0, 0};

	tx_symbol_encoder tx_symbol_encoder_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .tx_valid(tx_valid), .tx_byte(tx_byte),
		.tx_last(tx_last), .tx_ready(tx_ready), .tx_mod(tx_mod), .tx_active(tx_active));
	byte_source byte_source_inst (.pclk(pclk), .presetn(presetn), .tx_ready(tx_ready),
		.tx_mod(tx_mod), .tx_active(tx_active), .tx_valid(tx_valid), .tx_byte(tx_byte),
		.tx_last(tx_last));

	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end
	////////////////////////////////////////////////////////////////////////
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 95000) begin
			errors++;
			print_verdict();
		end
	end
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask
	function automatic int slot_len(input logic [2:0] code);
		int khz [8] = '{26, 26, 26, 53, 106, 212, 424, 848};
		return 10000 / (khz[code] * 8);
	endfunction
	////////////////////////////////////////////////////////////////////////
	task automatic apb(input logic [7:0] idx, input logic wr, input logic [7:0] wdata,
		output logic [31:0] rdata, output logic err);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= {22'h000000, idx, 2'b00};
		pwdata <= {24'h000000, wdata};
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		@(posedge pclk);
		while (pready !== 1'b1 && n < 100) begin
			@(posedge pclk);
			n++;
		end
		if (n >= 100) errors++;
		rdata = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		apb(idx, 1'b1, d, rd, er);
		if (idx >= enc_pkg::IDX_DATA_MOD && idx <= enc_pkg::IDX_P2)
			model_regs[idx - enc_pkg::IDX_DATA_MOD] = d;
	endtask
	task automatic check_regs();
		for (int i = 0; i < 7; i++) begin
			apb(enc_pkg::IDX_DATA_MOD + 8'(i), 1'b0, 8'h00, rd, er);
			check("register", rd, {24'h000000, model_regs[i]});
		end
	endtask
	////////////////////////////////////////////////////////////////////////
	// expected modulated cycles: patterns always go out direct, data per hi1/hi0
	// slots for a one or a zero bit; a negative hi1 marks a subcarrier envelope,
	// worked out cycle by cycle, and the miller bit takes its own pulse rule
	task automatic run_frame(input logic [7:0] mod, input logic [7:0] rates,
		input logic [7:0] ctrl, input int nbytes, input int hi1, input int hi0, input bit fixed);
		int sa, sb, ex, l0, l2, n;
		int bj, pb, ph, t, half;
		logic [15:0] p0;
		logic [7:0] p2, b;
		p0 = fixed ? 16'h0000 : 16'($random(seed));
		p2 = fixed ? 8'h00 : 8'($random(seed));
		l0 = fixed ? 0 : ($random(seed) & 15);
		l2 = fixed ? 0 : ($random(seed) & 7);
		wr(enc_pkg::IDX_DATA_MOD, mod);
		wr(enc_pkg::IDX_SYM_RATES, rates);
		wr(enc_pkg::IDX_P0_HIGH, p0[15:8]);
		wr(enc_pkg::IDX_P0_LOW, p0[7:0]);
		wr(enc_pkg::IDX_P2, p2);
		wr(enc_pkg::IDX_LEN, 8'((l2 << 4) | l0));
		sa = slot_len(rates[2:0]);
		sb = slot_len(rates[6:4]);
		ex = sa * $countones(p0 & 16'((1 << (l0 + 1)) - 1));
		ex = (mod[7] ? nbytes : 1) * 8 * (ex + sb * $countones(p2 & 8'((1 << (l2 + 1)) - 1)));
		half = 10000 / (2 * (rates[3] ? 848 : 424));
		byte_source_inst.clear_counts();
		for (int i = 0; i < nbytes; i++) begin
			b = fixed ? 8'h80 : 8'($random(seed));
			byte_source_inst.push({i == nbytes - 1, b});
			// subcarrier and previous bit restart whenever the load state is passed
			pb = (i == 0 || mod[7]) ? p0[0] : 0;
			t = (i == 0 || mod[7]) ? (l0 + 1) * 8 * sa : 0;
			for (int j = 0; j < 8; j++) begin
				bj = ctrl[7] ? b[7 - j] : b[j];
				if (mod[6]) begin
					ex += sa * (bj | !pb);
				end else if (hi1 < 0) begin
					for (int c = 0; c < 8 * sa; c++) begin
						ph = ((t + c) / half) & 1;
						ex += mod[0] ? (bj ^ ph) : (((c < 4 * sa) ? bj : !bj) & ph);
					end
				end else begin
					ex += bj ? hi1 * sa : hi0 * sa;
				end
				pb = bj;
				t += 8 * sa;
			end
		end
		wr(enc_pkg::IDX_CTRL, ctrl | 8'h01);
		n = 0;
		while (tx_active !== 1'b1 && n < 100) begin
			@(posedge pclk);
			n++;
		end
		if (n >= 100) errors++;
		while (tx_active !== 1'b0 && n < 40000) begin
			@(posedge pclk);
			n++;
		end
		if (n >= 40000) errors++;
		repeat (4) @(posedge pclk);
		check("mod cycles", 32'(byte_source_inst.high_cycles), 32'(ex));
		check("bytes taken", 32'(byte_source_inst.taken), 32'(nbytes));
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 32'h00000000;
		pwdata = 32'h00000000;
		errors = 0;
		checks_done = 0;
		cycles = 0;
		seed = 34;
		foreach (model_regs[i]) model_regs[i] = 8'h00;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		check_regs();
		apb(enc_pkg::IDX_LEN, 1'b0, 8'h00, rd, er);
		check("lengths", rd, 32'h00000000);
		// offsets 0..7 reach one unmapped word just past the patterns
		for (int i = 0; i < 24; i++) wr(enc_pkg::IDX_DATA_MOD + 8'($random(seed) & 7), 8'($random(seed)));
		check_regs();
		// a read straight after a write to the same pattern register
		wr(enc_pkg::IDX_P1_LOW, 8'h5a);
		apb(enc_pkg::IDX_P1_LOW, 1'b0, 8'h00, rd, er);
		check("readback", rd, 32'h0000005a);
		apb(8'h70, 1'b0, 8'h00, rd, er);
		check("unmapped error", {31'h00000000, er}, 32'h00000001);
		check("unmapped data", rd, 32'h00000000);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		foreach (model_regs[i]) model_regs[i] = 8'h00;
		check_regs();
		for (int k = 0; k < 8; k++)
			run_frame(8'(k), {4'h5, k[0], 3'h6}, 8'h00, 2, env_hi1[k], env_hi0[k], 0);
		run_frame(8'h08, 8'h66, 8'h00, 2, 0, 8, 0);
		run_frame(8'h80, 8'h66, 8'h80, 3, 8, 0, 0);
		for (int a = 2; a < 8; a++)
			run_frame(8'h00, {1'($random(seed)), 3'(9 - a), 1'($random(seed)), 3'(a)}, 8'h00, 2, 8, 0, 0);
		for (int p = 1; p < 4; p++) run_frame(8'(p << 4), 8'h66, 8'h00, 2, 1, 0, 0);
		run_frame(8'h50, 8'hde, 8'h00, 2, 0, 0, 0);
		run_frame(8'h00, 8'h66, 8'h80, 1, 8, 0, 1);
		check("high bit first", 32'(byte_source_inst.rise_at < 48), 32'h00000001);
		run_frame(8'h00, 8'h66, 8'h00, 1, 8, 0, 1);
		check("low bit first", 32'(byte_source_inst.rise_at > 80), 32'h00000001);
		print_verdict();
	end
endmodule
`default_nettype wire
